//--- sdef_pkg.sv
package sdef_pkg;

  // ==================================================================
  // bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ==================================================================
  // register byte offsets
  localparam logic [7:0]  OFF_STS_ONE   = 8'h38;
  localparam logic [7:0]  OFF_STS_TWO   = 8'h3c;
  localparam logic [7:0]  OFF_MASK_ONE  = 8'h40;
  localparam logic [7:0]  OFF_MASK_TWO  = 8'h44;
  localparam logic [7:0]  OFF_SDIO_STS  = 8'h68;
  localparam logic [7:0]  OFF_SDIO_MASK = 8'h6c;
  localparam logic [7:0]  OFF_IRQ_EN    = 8'h70;

  // ==================================================================
  // status one fields
  localparam int B1_RSP_DONE   = 0;
  localparam int B1_ACC_DONE   = 2;
  localparam int B1_CD_REMOVED = 3;
  localparam int B1_CD_INSERT  = 4;
  localparam int B1_CD_LEVEL   = 5;
  localparam int B1_WP_LEVEL   = 7;
  localparam int B1_D3_REMOVED = 8;
  localparam int B1_D3_INSERT  = 9;
  localparam int B1_D3_LEVEL   = 10;

  // ==================================================================
  // status two fields
  localparam int B2_CMD_ERR    = 0;
  localparam int B2_CRC_ERR    = 1;
  localparam int B2_END_ERR    = 2;
  localparam int B2_DATA_TO    = 3;
  localparam int B2_ILL_WR     = 4;
  localparam int B2_ILL_RD     = 5;
  localparam int B2_RSP_TO     = 6;
  localparam int B2_D0_LEVEL   = 7;
  localparam int B2_BUF_RD     = 8;
  localparam int B2_BUF_WR     = 9;
  localparam int B2_CLK_WR_OK  = 13;
  localparam int B2_CMD_BUSY   = 14;
  localparam int B2_ILL_ACC    = 15;

  // ==================================================================
  // sdio fields
  localparam int BS_CARD_IRQ   = 0;
  localparam int BS_EXT_A      = 14;
  localparam int BS_EXT_B      = 15;

  // ==================================================================
  // writable bit masks and reset values
  localparam logic [31:0] STS_ONE_RW    = 32'h0000031d;
  localparam logic [31:0] STS_TWO_RW    = 32'h0000837f;
  localparam logic [31:0] MASK_ONE_RW   = 32'h0000031d;
  localparam logic [31:0] MASK_TWO_RW   = 32'h0000837f;
  localparam logic [31:0] SDIO_STS_RW   = 32'h0000c001;
  localparam logic [31:0] SDIO_MASK_RW  = 32'h0000c007;
  localparam logic [31:0] SDIO_EVT_BITS = 32'h0000c001;
  localparam logic [31:0] IRQ_EN_RW     = 32'h00000003;
  localparam logic [31:0] SDIO_MASK_RST = 32'h00000006;
  localparam logic [31:0] ZERO_RST      = 32'h00000000;
  localparam int          EN_EVENT      = 0;
  localparam int          EN_SDIO       = 1;

  // ==================================================================
  // card pins, index order into the watcher
  localparam int PIN_N  = 4;
  localparam int PIN_CD = 0;
  localparam int PIN_WP = 1;
  localparam int PIN_D3 = 2;
  localparam int PIN_D0 = 3;
  localparam int PRIME_W = 3;

  // ==================================================================
  // carriers
  typedef struct packed {
    logic rsp_done;
    logic acc_done;
    logic cmd_err;
    logic crc_err;
    logic end_err;
    logic data_to;
    logic ill_wr;
    logic ill_rd;
    logic rsp_to;
    logic buf_readable;
    logic buf_writable;
    logic ill_access;
    logic card_irq;
    logic ext_a;
    logic ext_b;
  } sdef_evt_t;

  typedef struct packed {
    logic command_in_progress;
    logic clock_ctrl_writable;
  } sdef_core_state_t;

endpackage

//--- sdef_pin_watch.sv
`timescale 1ns/1ps
module sdef_pin_watch (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [sdef_pkg::PIN_N-1:0] pins_in,
  output logic      [sdef_pkg::PIN_N-1:0] level,
  output logic      [sdef_pkg::PIN_N-1:0] rise,
  output logic      [sdef_pkg::PIN_N-1:0] fall
);
  import sdef_pkg::*;

  logic [PIN_N-1:0]   s1_reg, s1_next;
  logic [PIN_N-1:0]   s2_reg, s2_next;
  logic [PIN_N-1:0]   s3_reg, s3_next;
  logic [PIN_N-1:0]   rise_reg, rise_next;
  logic [PIN_N-1:0]   fall_reg, fall_next;
  logic [PRIME_W-1:0] prime_reg, prime_next;

  // ==================================================================
  // two-flop sync, then edge compare
  // no edges until the chain has filled, so a pin already high at
  // reset release is not mistaken for an insertion
  always_comb begin
    s1_next    = pins_in;
    s2_next    = s1_reg;
    s3_next    = s2_reg;
    prime_next = {prime_reg[PRIME_W-2:0], 1'b1};
    // RULE23: edges of synced level
    rise_next  = prime_reg[PRIME_W-1] ? (s2_reg & ~s3_reg) : '0;
    fall_next  = prime_reg[PRIME_W-1] ? (~s2_reg & s3_reg) : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      rise_reg  <= '0;
      fall_reg  <= '0;
      prime_reg <= '0;
    end else begin
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      s3_reg    <= s3_next;
      rise_reg  <= rise_next;
      fall_reg  <= fall_next;
      prime_reg <= prime_next;
    end
  end

  assign level = s2_reg;
  assign rise  = rise_reg;
  assign fall  = fall_reg;

endmodule

//--- sdef_top.sv
// How it works
// RULE1: status one keeps response-done at b0, access-done at b2; b1 reads zero.
// RULE2: status one flags card-detect removal b3, insertion b4, live level b5.
// RULE3: status one flags line-3 removal b8, insertion b9, live level b10.
// RULE4: status one shows write-protect level at b7; b6 and above b10 read zero.
// RULE5: status two holds command, crc and end-bit error flags at b0..b2.
// RULE6: status two holds data timeout at b3 and response timeout at b6.
// RULE7: status two flags illegal buffer write at b4, illegal read at b5.
// RULE8: status two flags buffer readable at b8 and writable at b9.
// RULE9: status two shows live data line 0 level at b7.
// RULE10: status two b14 shows command in progress, read only.
// RULE11: status two b13 shows whether clock control may be written.
// RULE12: status two illegal access flag at b15; b10..b12, b16 up read zero.
// RULE13: software writes one to status two b11 and sdio mask b2..b1.
// RULE14: sdio mask holds card irq b0, extended events b14 and b15.
// RULE15: writes to read-only or reserved bits change nothing.
// RULE16: software disables controller entries before changing masks or flags.
// RULE17: sdio interrupt delivered only while its controller enable is set.
// RULE18: mask one holds b0, b2, b3, b4, b8, b9 writable.
// RULE19: mask two holds a bit per status two event flag.
// RULE20: sdio status holds card irq b0 and extended events b14, b15.
// RULE21: writing zero clears an event flag, writing one leaves it.
// RULE22: interrupt raised while any flag is set with its mask bit set; event_irq here also needs irqen_reg b0 (EN_EVENT) set.
// RULE23: pin insertion and removal flags set on synced pin edges.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module sdef_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [sdef_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [sdef_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire sdef_pkg::sdef_evt_t       core_evt,
  input  wire sdef_pkg::sdef_core_state_t core_state,
  input  wire logic                      card_detect_pin,
  input  wire logic                      write_protect_pin,
  input  wire logic                      data_line3_pin,
  input  wire logic                      data_line0_pin,
  output logic                           event_irq,
  output logic                           sdio_irq
);
  import sdef_pkg::*;

  // ==================================================================
  // helpers
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_STS_ONE) || (a == OFF_STS_TWO) || (a == OFF_MASK_ONE) ||
           (a == OFF_MASK_TWO) || (a == OFF_SDIO_STS) || (a == OFF_SDIO_MASK) ||
           (a == OFF_IRQ_EN);
  endfunction

  // sticky flag: hardware set beats a same-cycle software clear
  function automatic logic [31:0] flag_upd(input logic [31:0] cur,
                                           input logic        hit,
                                           input logic [31:0] clr,
                                           input logic [31:0] set,
                                           input logic [31:0] rw);
    return ((cur & ~(hit ? clr : '0)) | set) & rw;
  endfunction

  function automatic logic [31:0] ctl_upd(input logic [31:0] cur,
                                          input logic        hit,
                                          input logic [31:0] bm,
                                          input logic [31:0] wd,
                                          input logic [31:0] rw);
    return hit ? (((cur & ~bm) | (wd & bm)) & rw) : cur;
  endfunction

  // ==================================================================
  // pin watch
  logic [PIN_N-1:0] pin_level;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;
  logic [PIN_N-1:0] pins_raw;

  always_comb begin
    pins_raw         = '0;
    pins_raw[PIN_CD] = card_detect_pin;
    pins_raw[PIN_WP] = write_protect_pin;
    pins_raw[PIN_D3] = data_line3_pin;
    pins_raw[PIN_D0] = data_line0_pin;
  end

  sdef_pin_watch u_pins (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins_in (pins_raw),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // ==================================================================
  // register state
  logic [31:0]       sts1_reg, sts1_next;
  logic [31:0]       sts2_reg, sts2_next;
  logic [31:0]       msk1_reg, msk1_next;
  logic [31:0]       msk2_reg, msk2_next;
  logic [31:0]       ssts_reg, ssts_next;
  logic [31:0]       smsk_reg, smsk_next;
  logic [31:0]       irqen_reg, irqen_next;
  logic [31:0]       set1, set2, sets;
  logic [31:0]       rd1, rd2;

  // ==================================================================
  // bus state
  logic              aw_full_reg, aw_full_next;
  logic              w_full_reg, w_full_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [3:0]        wstrb_reg, wstrb_next;
  logic              awready_reg, awready_next;
  logic              wready_reg, wready_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic              eirq_reg, eirq_next;
  logic              sirq_reg, sirq_next;
  logic              wr_go;
  logic [31:0]       bm;
  logic [31:0]       clr;

  // ==================================================================
  // event sources
  always_comb begin
    set1 = '0;
    set2 = '0;
    sets = '0;
    // RULE1: completion events
    set1[B1_RSP_DONE]   = core_evt.rsp_done;
    set1[B1_ACC_DONE]   = core_evt.acc_done;
    // RULE2: card-detect edges
    set1[B1_CD_REMOVED] = pin_fall[PIN_CD];
    set1[B1_CD_INSERT]  = pin_rise[PIN_CD];
    // RULE3: line-3 edges
    set1[B1_D3_REMOVED] = pin_fall[PIN_D3];
    set1[B1_D3_INSERT]  = pin_rise[PIN_D3];
    // RULE5: protocol errors
    set2[B2_CMD_ERR]    = core_evt.cmd_err;
    set2[B2_CRC_ERR]    = core_evt.crc_err;
    set2[B2_END_ERR]    = core_evt.end_err;
    // RULE6: timeouts
    set2[B2_DATA_TO]    = core_evt.data_to;
    set2[B2_RSP_TO]     = core_evt.rsp_to;
    // RULE7: illegal buffer access
    set2[B2_ILL_WR]     = core_evt.ill_wr;
    set2[B2_ILL_RD]     = core_evt.ill_rd;
    // RULE8: buffer readiness
    set2[B2_BUF_RD]     = core_evt.buf_readable;
    set2[B2_BUF_WR]     = core_evt.buf_writable;
    // RULE12: illegal access
    set2[B2_ILL_ACC]    = core_evt.ill_access;
    // RULE20: sdio events
    sets[BS_CARD_IRQ]   = core_evt.card_irq;
    sets[BS_EXT_A]      = core_evt.ext_a;
    sets[BS_EXT_B]      = core_evt.ext_b;
  end

  // ==================================================================
  // read views with live monitors
  always_comb begin
    rd1              = sts1_reg;
    // RULE2: live card-detect
    rd1[B1_CD_LEVEL] = pin_level[PIN_CD];
    // RULE4: live write-protect
    rd1[B1_WP_LEVEL] = pin_level[PIN_WP];
    // RULE3: live line-3
    rd1[B1_D3_LEVEL] = pin_level[PIN_D3];
    rd2              = sts2_reg;
    // RULE9: live line-0
    rd2[B2_D0_LEVEL] = pin_level[PIN_D0];
    // RULE11: clock control writable
    rd2[B2_CLK_WR_OK] = core_state.clock_ctrl_writable;
    // RULE10: command busy
    rd2[B2_CMD_BUSY] = core_state.command_in_progress;
  end

  // ==================================================================
  // register update
  always_comb begin
    wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    bm    = strb_mask(wstrb_reg);
    clr   = bm & ~wdata_reg;
    // RULE21: zero clears, one keeps
    sts1_next = flag_upd(sts1_reg, wr_go && (awaddr_reg == OFF_STS_ONE), clr, set1,
                         STS_ONE_RW);
    sts2_next = flag_upd(sts2_reg, wr_go && (awaddr_reg == OFF_STS_TWO), clr, set2,
                         STS_TWO_RW);
    ssts_next = flag_upd(ssts_reg, wr_go && (awaddr_reg == OFF_SDIO_STS), clr, sets,
                         SDIO_STS_RW);
    // RULE15: read-only bits dropped by masks
    // RULE18: mask one bits
    msk1_next = ctl_upd(msk1_reg, wr_go && (awaddr_reg == OFF_MASK_ONE), bm, wdata_reg,
                        MASK_ONE_RW);
    // RULE19: mask two bits
    msk2_next = ctl_upd(msk2_reg, wr_go && (awaddr_reg == OFF_MASK_TWO), bm, wdata_reg,
                        MASK_TWO_RW);
    // RULE14: sdio mask bits
    smsk_next = ctl_upd(smsk_reg, wr_go && (awaddr_reg == OFF_SDIO_MASK), bm, wdata_reg,
                        SDIO_MASK_RW);
    irqen_next = ctl_upd(irqen_reg, wr_go && (awaddr_reg == OFF_IRQ_EN), bm, wdata_reg,
                         IRQ_EN_RW);
    // RULE22: flag and mask both high
    eirq_next = irqen_reg[EN_EVENT] &&
                (|(sts1_reg & msk1_reg) || |(sts2_reg & msk2_reg));
    // RULE17: sdio gated by its enable
    sirq_next = irqen_reg[EN_SDIO] && |(ssts_reg & smsk_reg & SDIO_EVT_BITS);
  end

  // ==================================================================
  // axi4-lite slave
  // one write and one read in flight; address and data taken in any order
  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_STS_ONE:   rdata_next = rd1;
        OFF_STS_TWO:   rdata_next = rd2;
        OFF_MASK_ONE:  rdata_next = msk1_reg;
        OFF_MASK_TWO:  rdata_next = msk2_reg;
        OFF_SDIO_STS:  rdata_next = ssts_reg;
        OFF_SDIO_MASK: rdata_next = smsk_reg;
        OFF_IRQ_EN:    rdata_next = irqen_reg;
        default:       rdata_next = '0;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    // refuse a new write while the last answer still waits
    awready_next = !aw_full_next && !bvalid_next;
    wready_next  = !w_full_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts1_reg    <= ZERO_RST;
      sts2_reg    <= ZERO_RST;
      msk1_reg    <= ZERO_RST;
      msk2_reg    <= ZERO_RST;
      ssts_reg    <= ZERO_RST;
      smsk_reg    <= SDIO_MASK_RST;
      irqen_reg   <= ZERO_RST;
      eirq_reg    <= 1'b0;
      sirq_reg    <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      sts1_reg    <= sts1_next;
      sts2_reg    <= sts2_next;
      msk1_reg    <= msk1_next;
      msk2_reg    <= msk2_next;
      ssts_reg    <= ssts_next;
      smsk_reg    <= smsk_next;
      irqen_reg   <= irqen_next;
      eirq_reg    <= eirq_next;
      sirq_reg    <= sirq_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign event_irq     = eirq_reg;
  assign sdio_irq      = sirq_reg;

endmodule

//--- sdef_checker.sv
`timescale 1ns/1ps
// ==================================================================
// bus handshake and reset checks at the top ports
module sdef_checker
  import sdef_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              event_irq,
  input wire logic              sdio_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return a inside {OFF_STS_ONE, OFF_STS_TWO, OFF_MASK_ONE, OFF_MASK_TWO,
                     OFF_SDIO_STS, OFF_SDIO_MASK, OFF_IRQ_EN};
  endfunction

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  reset_quiet_a: assert property ($rose(aresetn) |->
    !(event_irq || sdio_irq || s_axi_bvalid || s_axi_rvalid)) else $error("outputs busy after reset");
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  write_err_a: assert property (wr_taken |-> ##2 s_axi_bresp == (mapped($past(s_axi_awaddr, 2)) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response code wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid &&
    s_axi_rresp == (mapped($past(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR)) else $error("read answer wrong");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved while waiting");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
endmodule

bind sdef_top sdef_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .event_irq(event_irq), .sdio_irq(sdio_irq));

//--- sdef_card_model.sv
`timescale 1ns/1ps
// ==================================================================
// card side of the socket; pins move off the clock, like real contacts
module sdef_card_model #(
  parameter time LAT = 3ns
) (
  input  wire logic present,
  input  wire logic wp_on,
  input  wire logic busy,
  output logic      cd_pin,
  output logic      wp_pin,
  output logic      d3_pin,
  output logic      d0_pin
);
  assign #LAT cd_pin = present;
  assign #LAT wp_pin = wp_on;
  // seated card pulls line 3 up, socket pull-down otherwise
  assign #LAT d3_pin = present;
  // busy card holds line 0 low
  assign #LAT d0_pin = !busy;
endmodule

//--- sdef_top_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sdef_top_test;
  import sdef_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0]       wdata = '0;
  logic [31:0]       rdata;
  logic [1:0]        bresp;
  logic [1:0]        rresp;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, event_irq, sdio_irq;
  sdef_evt_t         core_evt = '0;
  sdef_core_state_t  core_state = '0;
  logic              present = 1'b0, wp_on = 1'b0, busy = 1'b0;
  logic              cd_pin, wp_pin, d3_pin, d0_pin;
  logic [7:0]        offs [4] = '{OFF_MASK_ONE, OFF_MASK_TWO, OFF_SDIO_MASK, OFF_IRQ_EN};
  logic [31:0]       rwm [4] = '{32'h31d, 32'h837f, 32'hc007, 32'h3};
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                cyc = 0;

  always #2.5 aclk = ~aclk;

  sdef_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_evt(core_evt),
    .core_state(core_state), .card_detect_pin(cd_pin), .write_protect_pin(wp_pin),
    .data_line3_pin(d3_pin), .data_line0_pin(d0_pin), .event_irq(event_irq), .sdio_irq(sdio_irq));
  sdef_card_model card (.present(present), .wp_on(wp_on), .busy(busy), .cd_pin(cd_pin),
    .wp_pin(wp_pin), .d3_pin(d3_pin), .d0_pin(d0_pin));

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==================================================================
  // bus tasks; the response is left waiting a cycle on purpose
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (!w_ok && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    `CHK(bresp, er)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b0;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask

  task automatic pulse(input sdef_evt_t e);
    core_evt <= e;
    @(posedge aclk);
    core_evt <= '0;
    repeat (3) @(posedge aclk);
  endtask

  // irq outputs lag the register state by a cycle
  task automatic irqs(input logic e, input logic s);
    repeat (3) @(posedge aclk);
    `CHK(event_irq, e)
    `CHK(sdio_irq, s)
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    // ==================================================================
    // reset state, no card
    rchk(OFF_STS_ONE, 32'h0, RESP_OKAY);
    rchk(OFF_STS_TWO, 32'h80, RESP_OKAY);
    rchk(OFF_SDIO_MASK, 32'h6, RESP_OKAY);
    rchk(8'h4c, 32'h0, RESP_SLVERR);
    wr(8'h00, 32'hffffffff, RESP_SLVERR);
    foreach (offs[i]) begin
      wr(offs[i], 32'hffffffff, RESP_OKAY);
      rchk(offs[i], rwm[i], RESP_OKAY);
    end
    wr(OFF_IRQ_EN, 32'h0, RESP_OKAY);
    pulse(15'h4000);
    irqs(1'b0, 1'b0);
    wr(OFF_IRQ_EN, 32'h1, RESP_OKAY);
    irqs(1'b1, 1'b0);
    wr(OFF_STS_ONE, 32'hfffffffe, RESP_OKAY);
    irqs(1'b0, 1'b0);
    // card irq needs its own enable
    pulse(15'h0004);
    irqs(1'b0, 1'b0);
    wr(OFF_IRQ_EN, 32'h3, RESP_OKAY);
    irqs(1'b0, 1'b1);
    wr(OFF_SDIO_MASK, 32'h6, RESP_OKAY);
    irqs(1'b0, 1'b0);
    wr(OFF_SDIO_MASK, 32'hc007, RESP_OKAY);
    irqs(1'b0, 1'b1);
    wr(OFF_SDIO_STS, 32'h0, RESP_OKAY);
    irqs(1'b0, 1'b0);
    wr(OFF_IRQ_EN, 32'h0, RESP_OKAY);
    present <= 1'b1;
    wp_on <= 1'b1;
    repeat (12) @(posedge aclk);
    rchk(OFF_STS_ONE, 32'h6b0, RESP_OKAY);
    present <= 1'b0;
    repeat (12) @(posedge aclk);
    wr(OFF_STS_ONE, 32'hfffffff7, RESP_OKAY);
    rchk(OFF_STS_ONE, 32'h390, RESP_OKAY);
    wr(OFF_STS_ONE, 32'h0, RESP_OKAY);
    rchk(OFF_STS_ONE, 32'h80, RESP_OKAY);
    // every core event, busy line, live state
    core_state <= 2'b11;
    busy <= 1'b1;
    pulse('1);
    rchk(OFF_STS_ONE, 32'h85, RESP_OKAY);
    rchk(OFF_STS_TWO, 32'he37f, RESP_OKAY);
    rchk(OFF_SDIO_STS, 32'hc001, RESP_OKAY);
    wr(OFF_STS_TWO, 32'h800, RESP_OKAY);
    rchk(OFF_STS_TWO, 32'h6000, RESP_OKAY);
    test_done();
  end
endmodule
